// ==== rtl/uart_irq_fifo_pkg.sv ====
// Constants shared by the UART interrupt identification and FIFO control block
package uart_irq_fifo_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_IDENT_FIFO = 8'h08;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] OFF_TIMEOUT = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

   // FIFO control write fields
   localparam int FCR_MODE_EN_BIT = 0;
   localparam int FCR_RX_RST_BIT = 1;
   localparam int FCR_TX_RST_BIT = 2;
   localparam int FCR_XFER_SEL_BIT = 3;
   localparam int FCR_TRIG_LSB = 4;

   // Identification read fields
   localparam int IDR_NIP_BIT = 0;
   localparam int IDR_ID_LSB = 1;
   localparam int IDR_XFER_BIT = 4;
   localparam int IDR_TRIG_LSB = 5;
   localparam int IDR_MODE_BIT = 7;

   // Interrupt id field codes, bits 3 to 1 of the identification value
   localparam logic [2:0] ID_LINE_STATUS = 3'h3;
   localparam logic [2:0] ID_RX_DATA = 3'h2;
   localparam logic [2:0] ID_RX_TIMEOUT = 3'h6;
   localparam logic [2:0] ID_TX_EMPTY = 3'h1;
   localparam logic [2:0] ID_MODEM = 3'h0;

   // Enable register bits
   localparam int EN_RX_DATA_BIT = 0;
   localparam int EN_TX_EMPTY_BIT = 1;
   localparam int EN_LINE_BIT = 2;
   localparam int EN_MODEM_BIT = 3;
   localparam int EN_MSR_CLEARS_BIT = 4;

   // Sticky status and mask bits
   localparam int ST_LINE_BIT = 0;
   localparam int ST_RX_DATA_BIT = 1;
   localparam int ST_RX_TIMEOUT_BIT = 2;
   localparam int ST_TX_EMPTY_BIT = 3;
   localparam int ST_MODEM_BIT = 4;

   // Reset values
   localparam logic [3:0] TRIG_RESET = 4'h0;
   localparam logic [4:0] ENABLE_RESET = 5'h00;
   localparam logic [7:0] TIMEOUT_RESET = 8'h20;
   localparam logic [4:0] MASK_RESET = 5'h00;

   // Core clock cycles per time-out tick
   localparam int TIMEOUT_TICK_CYCLES = 16;

endpackage

// ==== rtl/uart_irq_fifo_ctrl.sv ====
// UART interrupt identification, time-out and FIFO control with AHB-Lite registers
// Summary of operation
// - Overrun, parity, framing or break raises the top-priority line status source, id 0110, cleared by a line status read.
// - Receive data available, id 0100, is active while the receive fill is at or above the trigger level.
// - Receive time-out, id 1100, is raised when data sits idle for the set duration and is cleared by a receive buffer read.
// - Transmit holding empty, id 0010, is raised when the holding register becomes empty.
// - Transmit holding empty clears on an identification read that reports it or on a holding register write.
// - Modem status, id 0000, is raised on a clear-to-send change and optionally cleared by a modem status read.
// - Control bits 7 to 4 pick a trigger of 1, 4, 8, 14, 30, 46 or 62 bytes, all other codes 62.
// - The transfer mode select bit 3 has no function.
// - Writing one to bit 2 gives a one-cycle transmit FIFO reset pulse and the bit self-clears.
// - After that pulse the transmit FIFO pointer is zero and the FIFO is empty.
// - Writing one to bit 1 gives a one-cycle receive FIFO reset pulse and the bit self-clears.
// - After that pulse the receive FIFO pointer is zero and the FIFO is empty.
// - FIFO mode is always on and reads as one in bit 7, and a write to bit 0 only gates the other control bits.
// - A control write with bit 0 at zero programs none of the other control bits.
// - Bit 0 of the identification value reads one with nothing pending and zero when a source is reported.
// - One enable bit gates both receive data available and receive time-out.
`timescale 1ns/1ps

module uart_irq_fifo_ctrl #(
   parameter int FILL_W = 7,
   parameter int TICK_CYCLES = uart_irq_fifo_pkg::TIMEOUT_TICK_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Receive path status
   input wire logic [FILL_W-1:0] rx_fill,
   input wire logic rx_push,
   input wire logic line_error,
   input wire logic line_status_read,
   input wire logic rx_buffer_read,
   // Transmit path status
   input wire logic tx_holding_empty,
   input wire logic tx_holding_write,
   // Modem pins and status access
   input wire logic clear_to_send,
   input wire logic modem_status_read,
   // FIFO reset pulses
   output logic tx_fifo_reset,
   output logic rx_fifo_reset,
   // Interrupts
   output logic uart_irq,
   output logic irq
);
   import uart_irq_fifo_pkg::*;

   // Tick divider width and reload value
   localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [7:0] rdata;
      logic ready;
      logic [3:0] trig;
      logic [4:0] enable;
      logic [7:0] timeout;
      logic [4:0] status;
      logic [4:0] mask;
      logic line_pend;
      logic tout_pend;
      logic thre_pend;
      logic modem_pend;
      logic rx_data_q;
      logic src_irq;
      logic irq;
      logic tx_rst;
      logic rx_rst;
      logic [1:0] cts_sync;
      logic cts_prev;
      logic [TICK_W-1:0] div;
      logic [7:0] idle;
   } state_t;

   state_t s;
   state_t next_s;

   // Trigger code to byte count
   function automatic logic [6:0] trig_bytes(input logic [3:0] code);
      case (code)
         4'h0: trig_bytes = 7'h01;
         4'h1: trig_bytes = 7'h04;
         4'h2: trig_bytes = 7'h08;
         4'h3: trig_bytes = 7'h0e;
         4'h4: trig_bytes = 7'h1e;
         4'h5: trig_bytes = 7'h2e;
         default: trig_bytes = 7'h3e;
      endcase
   endfunction

   logic acc;
   logic rd;
   logic rx_data_now;
   logic no_pending_flag;
   logic [2:0] interrupt_id_field;
   logic [7:0] ident;
   logic tick;
   logic activity;
   logic tout_set;
   logic cts_change;
   logic [4:0] events;
   logic [4:0] status_clr;
   logic [7:0] wdata;
   logic sel_ident;
   logic sel_status;
   logic line_clr;
   logic tout_clr;
   logic thre_clr;
   logic modem_clr;
   logic [7:0] rd_word;
   logic [4:0] next_status;

   // Bus decode, only the low address byte selects a register
   always_comb begin
      acc = hsel & htrans[1] & hready;
      rd = acc & ~hwrite;
      wdata = hwdata[7:0];
      sel_ident = (haddr[7:0] == OFF_IDENT_FIFO);
      sel_status = (haddr[7:0] == OFF_IRQ_STATUS);
   end

   // Priority encoder over enabled sources
   always_comb begin
      // Level compare, so the source drops as soon as the fill falls below
      rx_data_now = ({{(32 - FILL_W){1'b0}}, rx_fill} >= {25'h0, trig_bytes(s.trig)});
      no_pending_flag = 1'b0;
      interrupt_id_field = ID_MODEM;
      if (s.enable[EN_LINE_BIT] && s.line_pend) begin
         interrupt_id_field = ID_LINE_STATUS;
      end else if (s.enable[EN_RX_DATA_BIT] && rx_data_now) begin
         interrupt_id_field = ID_RX_DATA;
      end else if (s.enable[EN_RX_DATA_BIT] && s.tout_pend) begin
         interrupt_id_field = ID_RX_TIMEOUT;
      end else if (s.enable[EN_TX_EMPTY_BIT] && s.thre_pend) begin
         interrupt_id_field = ID_TX_EMPTY;
      end else if (s.enable[EN_MODEM_BIT] && s.modem_pend) begin
         interrupt_id_field = ID_MODEM;
      end else begin
         no_pending_flag = 1'b1;
      end
      ident = 8'h00;
      ident[IDR_NIP_BIT] = no_pending_flag;
      ident[IDR_ID_LSB +: 3] = interrupt_id_field;
      ident[IDR_XFER_BIT] = 1'b0;
      ident[IDR_TRIG_LSB +: 2] = s.trig[1:0];
      ident[IDR_MODE_BIT] = 1'b1;
   end

   // Time-out tick divider and idle detection
   always_comb begin
      tick = (s.div == '0);
      activity = rx_push | rx_buffer_read | (rx_fill == '0);
      // The idle count halts at the limit, so the source is raised once
      tout_set = ~activity & tick & (s.idle + 8'h01 == s.timeout);
   end

   // Clear conditions and status events
   always_comb begin
      cts_change = s.cts_sync[1] ^ s.cts_prev;
      line_clr = line_status_read;
      // A receive FIFO reset also drops a pending time-out
      tout_clr = rx_buffer_read | s.rx_rst;
      // Identification read clears transmit holding empty, and only when it reports that source
      thre_clr = tx_holding_write | (rd & sel_ident & ~no_pending_flag & (interrupt_id_field == ID_TX_EMPTY));
      // Modem status read clears only when enabled
      modem_clr = modem_status_read & s.enable[EN_MSR_CLEARS_BIT];
      events = 5'h00;
      events[ST_LINE_BIT] = line_error;
      events[ST_RX_DATA_BIT] = rx_data_now & ~s.rx_data_q;
      events[ST_RX_TIMEOUT_BIT] = tout_set;
      events[ST_TX_EMPTY_BIT] = tx_holding_empty;
      events[ST_MODEM_BIT] = cts_change;
      status_clr = (rd && sel_status) ? 5'h1f : 5'h00;
   end

   // Read data, latched at the address edge
   always_comb begin
      case (haddr[7:0])
         OFF_IDENT_FIFO: rd_word = ident;
         OFF_IRQ_ENABLE: rd_word = {3'h0, s.enable};
         OFF_TIMEOUT: rd_word = s.timeout;
         OFF_IRQ_STATUS: rd_word = {3'h0, s.status};
         OFF_IRQ_MASK: rd_word = {3'h0, s.mask};
         default: rd_word = 8'h00;
      endcase
   end

   // Sticky status, an event in the clearing cycle still lands
   for (genvar b = 0; b < 5; b++) begin : g_status
      assign next_status[b] = events[b] | (s.status[b] & ~status_clr[b]);
   end

   always_comb begin
      next_s = s;
      next_s.div = tick ? TICK_LAST : s.div - 1'b1;
      if (activity) begin
         next_s.idle = 8'h00;
      end else if (tick && s.idle != s.timeout) begin
         next_s.idle = s.idle + 8'h01;
      end

      // Clear-to-send change detect after two-stage sync
      next_s.cts_sync = {s.cts_sync[0], clear_to_send};
      next_s.cts_prev = s.cts_sync[1];

      // Pending sources, set wins over clear
      if (line_error) begin
         next_s.line_pend = 1'b1;
      end else if (line_clr) begin
         next_s.line_pend = 1'b0;
      end
      if (tout_set) begin
         next_s.tout_pend = 1'b1;
      end else if (tout_clr) begin
         next_s.tout_pend = 1'b0;
      end
      if (tx_holding_empty) begin
         next_s.thre_pend = 1'b1;
      end else if (thre_clr) begin
         next_s.thre_pend = 1'b0;
      end
      if (cts_change) begin
         next_s.modem_pend = 1'b1;
      end else if (modem_clr) begin
         next_s.modem_pend = 1'b0;
      end
      // Previous level, for the rising-edge status event
      next_s.rx_data_q = rx_data_now;

      // Register read, answered with no wait state
      next_s.ready = 1'b1;
      if (rd) begin
         next_s.rdata = rd_word;
      end

      // Register write, data phase
      next_s.wr_pend = acc & hwrite;
      next_s.wr_addr = haddr[7:0];
      next_s.tx_rst = 1'b0;
      next_s.rx_rst = 1'b0;
      if (s.wr_pend) begin
         case (s.wr_addr)
            OFF_IDENT_FIFO: begin
               // Without the mode bit the whole control write is dropped
               if (wdata[FCR_MODE_EN_BIT]) begin
                  next_s.trig = wdata[FCR_TRIG_LSB +: 4];
                  next_s.tx_rst = wdata[FCR_TX_RST_BIT];
                  next_s.rx_rst = wdata[FCR_RX_RST_BIT];
               end
            end
            OFF_IRQ_ENABLE: next_s.enable = wdata[4:0];
            OFF_TIMEOUT: next_s.timeout = wdata;
            OFF_IRQ_MASK: next_s.mask = wdata[4:0];
            default: begin
            end
         endcase
      end

      // Status and interrupt move on the same edge
      next_s.status = next_status;
      next_s.irq = |(next_status & next_s.mask);
      next_s.src_irq = ~no_pending_flag;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         // Ready high through reset, a zero-wait slave never stalls
         s.ready <= 1'b1;
         s.trig <= TRIG_RESET;
         s.enable <= ENABLE_RESET;
         s.timeout <= TIMEOUT_RESET;
         s.mask <= MASK_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Upper bytes of every register read as zero
   assign hrdata = {24'h000000, s.rdata};
   assign hreadyout = s.ready;
   assign hresp = 1'b0;
   assign tx_fifo_reset = s.tx_rst;
   assign rx_fifo_reset = s.rx_rst;
   assign uart_irq = s.src_irq;
   assign irq = s.irq;

endmodule

// ==== testbench/uart_irq_fifo_asserts.sv ====
// Checker for FIFO control pulses and identification reads
`timescale 1ns/1ps
module uart_irq_fifo_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   // Pulses
   input wire logic tx_fifo_reset,
   input wire logic rx_fifo_reset
);
   logic acc;
   logic wr_ph;
   logic rd_ph;
   logic txq;
   logic rxq;
   assign acc = hsel && htrans[1] && hready && haddr[7:0] == 8'h08;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ph <= 1'b0;
         rd_ph <= 1'b0;
         txq <= 1'b0;
         rxq <= 1'b0;
      end else begin
         wr_ph <= acc && hwrite;
         rd_ph <= acc && !hwrite;
         txq <= wr_ph && hwdata[0] && hwdata[2];
         rxq <= wr_ph && hwdata[0] && hwdata[1];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_tx;
      wr_ph && hwdata[0] && hwdata[2];
   endsequence
   sequence s_rx;
      wr_ph && hwdata[0] && hwdata[1];
   endsequence
   a_tx_pulse: assert property (s_tx |=> tx_fifo_reset ##1 !tx_fifo_reset)
      else $error("tx reset pulse wrong");
   a_tx_cause: assert property (tx_fifo_reset |-> txq)
      else $error("tx reset without request");
   a_rx_pulse: assert property (s_rx |=> rx_fifo_reset ##1 !rx_fifo_reset)
      else $error("rx reset pulse wrong");
   a_rx_cause: assert property (rx_fifo_reset |-> rxq)
      else $error("rx reset without request");
   a_mode_bit: assert property (rd_ph |-> hrdata[7])
      else $error("fifo mode bit not one");
   a_xfer_bit: assert property (rd_ph |-> !hrdata[4])
      else $error("transfer mode bit set");
   a_none_id: assert property (rd_ph && hrdata[0] |-> hrdata[3:1] == 3'h0)
      else $error("id field set with none pending");
   a_id_legal: assert property (rd_ph && !hrdata[0] |-> hrdata[3:1] inside {3'h3, 3'h2, 3'h6, 3'h1, 3'h0})
      else $error("bad id code");
endmodule

bind uart_irq_fifo_ctrl uart_irq_fifo_asserts i_uart_irq_fifo_asserts (.core_clk(core_clk),
   .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .tx_fifo_reset(tx_fifo_reset),
   .rx_fifo_reset(rx_fifo_reset));

// ==== testbench/uart_path_model.sv ====
// Model of the receive, transmit and modem paths around the block
`timescale 1ns/1ps
module uart_path_model (
   // Clock
   input wire logic core_clk,
   // Reset pulse from the block
   input wire logic rx_fifo_reset,
   // Path status
   output logic [6:0] rx_fill,
   output logic [6:0] ev,
   output logic clear_to_send
);
   initial begin
      rx_fill = 7'h00;
      ev = 7'h00;
      clear_to_send = 1'b0;
   end
   always @(posedge core_clk)
      if (rx_fifo_reset) rx_fill <= 7'h00;
   task pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
   endtask
   task fill(input logic [6:0] v);
      @(posedge core_clk);
      rx_fill <= v;
   endtask
   task cts;
      @(posedge core_clk);
      clear_to_send <= !clear_to_send;
   endtask
endmodule

// ==== testbench/test_uart_irq_fifo_ctrl.sv ====
// Testbench for the UART interrupt identification and FIFO control block
`timescale 1ns/1ps
module test_uart_irq_fifo_ctrl;
   logic core_clk = 0, reset_n = 0, hsel = 0, hwrite = 0;
   logic [2:0] hsize = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0;
   logic hreadyout, hresp, txr, rxr, uart_irq, irq, cts;
   logic [6:0] fill, ev;
   int bad_count = 0, n_tests = 0, npul = 0;
   int lv[9] = '{1, 4, 8, 14, 30, 46, 62, 62, 62};
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) npul += txr + rxr;
   uart_path_model i_uart_path_model (.core_clk(core_clk), .rx_fifo_reset(rxr),
      .rx_fill(fill), .ev(ev), .clear_to_send(cts));
   uart_irq_fifo_ctrl #(.TICK_CYCLES(2)) i_uart_irq_fifo_ctrl (.core_clk(core_clk),
      .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rx_fill(fill), .rx_push(ev[0]),
      .line_error(ev[1]), .line_status_read(ev[2]), .rx_buffer_read(ev[3]),
      .tx_holding_empty(ev[4]), .tx_holding_write(ev[5]), .clear_to_send(cts),
      .modem_status_read(ev[6]), .tx_fifo_reset(txr), .rx_fifo_reset(rxr),
      .uart_irq(uart_irq), .irq(irq));
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      hsize <= 3'h2;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(q, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   // Identification word: mode one, low trigger bits, transfer bit zero
   function logic [31:0] idv(input int c, input logic [3:0] low);
      return {24'h0, 1'b1, 2'(c), 1'b0, low};
   endfunction
   task pl(input int i);
      i_uart_path_model.pulse(i);
   endtask
   initial begin
      #50000;
      bad_count++;
      close_out;
   end
   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(8'h08, idv(0, 4'h1));
      rd(8'h14, 32'h20);
      rd(8'h40, 32'h0);
      bus(8'h14, 1'b1, 32'h0);
      bus(8'h10, 1'b1, 32'h1);
      for (int c = 0; c < 9; c++) begin
         bus(8'h08, 1'b1, {24'h0, 4'(c), 4'h9});
         i_uart_path_model.fill(7'(lv[c] - 1));
         rd(8'h08, idv(c, 4'h1));
         i_uart_path_model.fill(7'(lv[c]));
         rd(8'h08, idv(c, 4'h4));
      end
      bus(8'h08, 1'b1, 32'h10);
      i_uart_path_model.fill(7'h04);
      rd(8'h08, idv(8, 4'h1));
      bus(8'h10, 1'b1, 32'h0);
      i_uart_path_model.fill(7'h3e);
      rd(8'h08, idv(8, 4'h1));
      $display("trigger test done");
      bus(8'h10, 1'b1, 32'h1f);
      pl(4);
      pl(1);
      rd(8'h08, idv(8, 4'h6));
      chk({31'h0, uart_irq}, 32'h1);
      pl(2);
      rd(8'h08, idv(8, 4'h4));
      i_uart_path_model.fill(7'h00);
      rd(8'h08, idv(8, 4'h2));
      rd(8'h08, idv(8, 4'h1));
      pl(4);
      pl(5);
      rd(8'h08, idv(8, 4'h1));
      i_uart_path_model.cts;
      repeat (4) @(posedge core_clk);
      rd(8'h08, idv(8, 4'h0));
      pl(6);
      rd(8'h08, idv(8, 4'h1));
      chk({31'h0, uart_irq}, 32'h0);
      $display("priority test done");
      bus(8'h14, 1'b1, 32'h1);
      i_uart_path_model.fill(7'h01);
      pl(0);
      repeat (8) @(posedge core_clk);
      rd(8'h08, idv(8, 4'hc));
      i_uart_path_model.fill(7'h00);
      pl(3);
      rd(8'h08, idv(8, 4'h1));
      $display("timeout test done");
      bus(8'h18, 1'b0, 32'h0);
      bus(8'h1c, 1'b1, 32'h8);
      pl(4);
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      rd(8'h18, 32'h8);
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      pl(5);
      pl(1);
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      pl(2);
      bus(8'h18, 1'b0, 32'h0);
      bus(8'h18, 1'b1, 32'h1f);
      rd(8'h18, 32'h0);
      $display("status test done");
      bus(8'h08, 1'b1, 32'h87);
      repeat (2) @(posedge core_clk);
      chk(npul, 32'h2);
      bus(8'h08, 1'b1, 32'h86);
      repeat (2) @(posedge core_clk);
      chk(npul, 32'h2);
      $display("fifo reset test done");
      close_out;
   end
endmodule
